// >>> hwr_pkg.sv
// constants and helpers shared by the hardware-register read unit
package hwr_pkg;
  localparam int          DATA_W        = 32;
  localparam int          SEL_W         = 5;
  localparam int          DEST_W        = 5;
  localparam int          CPU_NUM_W     = 10;
  localparam int          DIV_W         = 16;
  localparam logic [4:0]  SEL_CPU_NUM   = 5'h00;
  localparam logic [4:0]  SEL_SYNC_STEP = 5'h01;
  localparam logic [4:0]  SEL_COUNT     = 5'h02;
  localparam logic [4:0]  SEL_COUNT_RES = 5'h03;
  localparam logic [4:0]  SEL_RSVD_LO   = 5'h04;
  localparam logic [4:0]  SEL_RSVD_HI   = 5'h1C;
  localparam logic [4:0]  SEL_THREAD    = 5'h1D;
  localparam logic [4:0]  SEL_IMPL_A    = 5'h1E;
  localparam logic [4:0]  SEL_IMPL_B    = 5'h1F;
  localparam int          MIN_RELEASE   = 2;
  localparam logic [31:0] MASK_RST      = 32'h0000_0000;
  localparam logic [31:0] DATA_RST      = 32'h0000_0000;
  localparam logic [31:0] COUNT_RST     = 32'h0000_0000;
  localparam logic [15:0] DIV_RST       = 16'h0000;

  // selector is backed by hardware in this build
  function automatic logic hwr_implemented(input logic [4:0] sel,
                                           input logic       thread_en,
                                           input logic       impl_a_en,
                                           input logic       impl_b_en);
    logic hit;
    hit = 1'b0;
    case (sel)
      SEL_CPU_NUM, SEL_SYNC_STEP, SEL_COUNT, SEL_COUNT_RES: hit = 1'b1;
      SEL_THREAD: hit = thread_en;
      SEL_IMPL_A: hit = impl_a_en;
      SEL_IMPL_B: hit = impl_b_en;
      default:    hit = 1'b0;
    endcase
    return hit;
  endfunction
endpackage

// >>> count_if.sv
// carrier between the read unit and its cycle counter
`timescale 1ns/100ps
interface count_if;
  logic [31:0] count;
  logic        tick;
  logic        we;
  logic [31:0] wdata;
  modport ctr  (output count, output tick, input we, input wdata);
  modport user (input count, input tick, output we, output wdata);
endinterface

// >>> cycle_counter.sv
// cycle counter advancing once every res cycles
`timescale 1ns/100ps
module cycle_counter #(
  parameter logic [15:0] CC_RES = 16'h0001
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  count_if.ctr      cif
);
  import hwr_pkg::*;

  logic [15:0] div_r;
  logic [15:0] div_nxt;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic        tick;

  // a res of zero is treated as one so the counter never stalls
  assign tick = (div_r >= CC_RES - 16'h0001) || (CC_RES == 16'h0000);

  always_comb begin
    div_nxt   = tick ? DIV_RST : div_r + 16'h0001;
    count_nxt = count_r;
    if (cif.we) begin
      count_nxt = cif.wdata;
    end else if (tick) begin
      count_nxt = count_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_r   <= DIV_RST;
      count_r <= COUNT_RST;
    end else begin
      div_r   <= div_nxt;
      count_r <= count_nxt;
    end
  end

  assign cif.count = count_r;
  assign cif.tick  = tick;

  res_spacing_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !cif.we && !tick |=> count_r == $past(count_r))
    else $error("counter moved between resolution ticks");
endmodule // cycle_counter

// >>> hw_register_read_unit.sv
// execution logic for the user-mode hardware-register read instruction
// Functional notes
// - permitted read writes selected value to destination
// - per-register access from enable mask bit
// - selector 0 returns processor index
// - selector 1 returns cache sync step
// - selector 2 returns cycle counter
// - selector 3 returns counter resolution
// - selectors 4 to 28 raise exception
// - selector 29 returns thread-local word
// - selectors 30, 31 optional, else exception
// - first-release build treats instruction as reserved
// - permit when coprocessor enabled or mask set
// - exception when denied or unimplemented
`timescale 1ns/100ps
module hw_register_read_unit #(
  parameter int          ARCH_RELEASE = 2,
  parameter logic [31:0] SYNC_STEP    = 32'h0000_0000,
  parameter logic [15:0] CC_RES       = 16'h0001,
  parameter logic        THREAD_EN    = 1'b1,
  parameter logic        IMPL_A_EN    = 1'b0,
  parameter logic        IMPL_B_EN    = 1'b0,
  parameter logic [31:0] IMPL_A_VAL   = 32'h0000_0000,
  parameter logic [31:0] IMPL_B_VAL   = 32'h0000_0000
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_valid,
  input  wire logic [hwr_pkg::SEL_W-1:0]     i_sel,
  input  wire logic [hwr_pkg::DEST_W-1:0]    i_dest_field,
  input  wire logic                          i_cp0_enabled,
  input  wire logic [hwr_pkg::CPU_NUM_W-1:0] i_exception_base_cpu,
  input  wire logic [hwr_pkg::DATA_W-1:0]    i_thread_local_word,
  input  wire logic                          i_mask_we,
  input  wire logic [hwr_pkg::DATA_W-1:0]    i_mask_wdata,
  input  wire logic                          i_count_we,
  input  wire logic [hwr_pkg::DATA_W-1:0]    i_count_wdata,
  output logic                               o_wr_en,
  output logic [hwr_pkg::DEST_W-1:0]         o_wr_addr,
  output logic [hwr_pkg::DATA_W-1:0]         o_wr_data,
  output logic                               o_ri_exc,
  output logic                               o_done,
  output logic [hwr_pkg::DATA_W-1:0]         o_hw_read_enable_mask,
  output logic [hwr_pkg::DATA_W-1:0]         o_count
);
  import hwr_pkg::*;

  count_if cif ();

  cycle_counter #(
    .CC_RES (CC_RES)
  ) u_ctr (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .cif   (cif)
  );

  logic [31:0] sel_value;

  hw_sel_mux #(
    .SYNC_STEP  (SYNC_STEP),
    .CC_RES     (CC_RES),
    .IMPL_A_VAL (IMPL_A_VAL),
    .IMPL_B_VAL (IMPL_B_VAL)
  ) u_mux (
    .i_sel    (i_sel),
    .i_cpu    (i_exception_base_cpu),
    .i_count  (cif.count),
    .i_thread (i_thread_local_word),
    .o_value  (sel_value)
  );

  logic              sel_mask_bit;
  logic [31:0]       hw_read_enable_mask_r;
  logic [31:0]       hw_read_enable_mask_nxt;
  logic              wr_en_r;
  logic              wr_en_nxt;
  logic [4:0]        wr_addr_r;
  logic [4:0]        wr_addr_nxt;
  logic [31:0]       wr_data_r;
  logic [31:0]       wr_data_nxt;
  logic              exc_r;
  logic              exc_nxt;
  logic              done_r;
  logic              done_nxt;
  logic [31:0]       count_r;
  logic              permit;
  logic              impl;
  logic              release_ok;
  logic              fault;

  // a first-release core never executes this instruction
  assign release_ok = (ARCH_RELEASE >= MIN_RELEASE);
  assign permit     = i_cp0_enabled || hw_read_enable_mask_r[i_sel];
  assign impl       = hwr_implemented(i_sel, THREAD_EN, IMPL_A_EN, IMPL_B_EN);
  assign fault      = !release_ok || !impl || !permit;
  assign sel_mask_bit = hw_read_enable_mask_r[i_sel];

  always_comb begin
    hw_read_enable_mask_nxt = i_mask_we ? i_mask_wdata : hw_read_enable_mask_r;
    wr_en_nxt               = i_valid && !fault;
    exc_nxt                 = i_valid && fault;
    done_nxt                = i_valid;
    wr_addr_nxt             = wr_addr_r;
    wr_data_nxt             = wr_data_r;
    // data and address only move on a real write, so a faulting read disturbs nothing
    if (i_valid && !fault) begin
      wr_addr_nxt = i_dest_field;
      wr_data_nxt = sel_value;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      hw_read_enable_mask_r <= MASK_RST;
      wr_en_r               <= 1'b0;
      wr_addr_r             <= 5'h00;
      wr_data_r             <= DATA_RST;
      exc_r                 <= 1'b0;
      done_r                <= 1'b0;
      count_r               <= COUNT_RST;
    end else begin
      hw_read_enable_mask_r <= hw_read_enable_mask_nxt;
      wr_en_r               <= wr_en_nxt;
      wr_addr_r             <= wr_addr_nxt;
      wr_data_r             <= wr_data_nxt;
      exc_r                 <= exc_nxt;
      done_r                <= done_nxt;
      count_r               <= cif.count;
    end
  end

  assign cif.we                = i_count_we;
  assign cif.wdata             = i_count_wdata;
  assign o_wr_en               = wr_en_r;
  assign o_wr_addr             = wr_addr_r;
  assign o_wr_data             = wr_data_r;
  assign o_ri_exc              = exc_r;
  assign o_done                = done_r;
  assign o_hw_read_enable_mask = hw_read_enable_mask_r;
  // o_count lags the live counter by one cycle to stay a flop output
  assign o_count               = count_r;

  // own count of cycles between ticks, kept apart from the divider it checks
  logic [15:0]       gap_r;
  logic [15:0]       gap_nxt;

  always_comb begin
    gap_nxt = cif.tick ? 16'h0000 : gap_r + 16'h0001;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  sequence issue_ok;
    i_valid && release_ok && impl && (i_cp0_enabled || sel_mask_bit);
  endsequence

  sequence issue_sel(logic [4:0] s);
    issue_ok ##0 (i_sel == s);
  endsequence

  sequence issue_bad;
    i_valid && (!release_ok || !impl || !(i_cp0_enabled || sel_mask_bit));
  endsequence

  sequence answer_ok;
    o_done && o_wr_en && !o_ri_exc;
  endsequence

  sequence answer_bad;
    o_done && o_ri_exc && !o_wr_en;
  endsequence

  sequence answer_none;
    !o_done && !o_wr_en && !o_ri_exc;
  endsequence

  write_dest_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_ok |=> o_wr_en && !o_ri_exc && o_wr_addr == $past(i_dest_field))
    else $error("permitted read did not write destination");

  mask_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && !i_cp0_enabled && !hw_read_enable_mask_r[i_sel] |=> o_ri_exc && !o_wr_en)
    else $error("masked read was not refused");

  cp0_permit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_cp0_enabled && release_ok && impl |=> o_wr_en)
    else $error("enabled coprocessor read was refused");

  cpu_index_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_sel(SEL_CPU_NUM) |=> o_wr_data == {22'h000000, $past(i_exception_base_cpu)})
    else $error("processor index read wrong");

  sync_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_sel(SEL_SYNC_STEP) |=> o_wr_data == SYNC_STEP)
    else $error("sync step read wrong");

  count_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_sel(SEL_COUNT) |=> o_wr_data == $past(cif.count))
    else $error("cycle count read wrong");

  count_res_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_sel(SEL_COUNT_RES) |=> o_wr_data == {16'h0000, CC_RES})
    else $error("counter resolution read wrong");

  reserved_sel_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_sel >= SEL_RSVD_LO && i_sel <= SEL_RSVD_HI |=> o_ri_exc && !o_wr_en)
    else $error("reserved selector did not fault");

  thread_word_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_sel(SEL_THREAD) |=> o_wr_data == $past(i_thread_local_word))
    else $error("thread-local word read wrong");

  impl_slot_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && ((i_sel == SEL_IMPL_A && !IMPL_A_EN) || (i_sel == SEL_IMPL_B && !IMPL_B_EN)) |=> o_ri_exc)
    else $error("unimplemented slot did not fault");

  old_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && !release_ok |=> o_ri_exc)
    else $error("first-release build executed the read");

  fault_any_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_bad |=> o_ri_exc ##1 !o_ri_exc || $past(i_valid))
    else $error("denied read did not fault");

  dest_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_ri_exc |-> !o_wr_en && $stable(o_wr_data) && $stable(o_wr_addr))
    else $error("faulting read touched destination");

  // outcome pulses pair with issues one to one; a reset in flight drops the attempt
  ok_answer_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_ok |=> answer_ok)
    else $error("permitted read gave no clean write pulse");

  bad_answer_a: assert property (@(posedge i_clk) disable iff (i_rst)
    issue_bad |=> answer_bad)
    else $error("refused read gave no clean fault pulse");

  idle_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_valid |=> answer_none)
    else $error("result pulse without an issued read");

  one_answer_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |-> o_wr_en != o_ri_exc)
    else $error("completion without exactly one outcome");

  wr_done_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_wr_en |-> o_done)
    else $error("write pulse without completion");

  exc_done_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_ri_exc |-> o_done)
    else $error("fault pulse without completion");

  done_source_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done |-> $past(i_valid))
    else $error("completion without an issued read");

  idle_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_valid |=> $stable(o_wr_data) && $stable(o_wr_addr))
    else $error("destination moved while idle");

  rsvd_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_sel >= SEL_RSVD_LO && i_sel <= SEL_RSVD_HI |=> $stable(o_wr_data) && $stable(o_wr_addr))
    else $error("reserved selector changed destination");

  mask_allow_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && release_ok && impl && !i_cp0_enabled && sel_mask_bit |=> o_wr_en)
    else $error("mask-enabled read was refused");

  release_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !release_ok |-> !o_wr_en)
    else $error("first-release build wrote destination");

  mask_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_mask_we |=> o_hw_read_enable_mask == $past(i_mask_wdata))
    else $error("enable mask write lost");

  mask_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_mask_we |=> $stable(o_hw_read_enable_mask))
    else $error("enable mask moved without a write");

  // counter checks read the live count; o_count lags it by one cycle
  count_load_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_count_we |=> cif.count == $past(i_count_wdata))
    else $error("counter load lost");

  count_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_count_we && cif.tick |=> cif.count == $past(cif.count) + 32'h0000_0001)
    else $error("counter did not step on tick");

  count_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst |=> o_count == $past(cif.count))
    else $error("counter output does not follow counter");

  tick_gap_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cif.tick == ((CC_RES <= 16'h0001) || (gap_r == CC_RES - 16'h0001)))
    else $error("counter tick spacing differs from resolution");
endmodule // hw_register_read_unit

// >>> hw_sel_mux.sv
// value mux for the hardware-register selector
`timescale 1ns/100ps
module hw_sel_mux #(
  parameter logic [31:0] SYNC_STEP  = 32'h0000_0000,
  parameter logic [15:0] CC_RES     = 16'h0001,
  parameter logic [31:0] IMPL_A_VAL = 32'h0000_0000,
  parameter logic [31:0] IMPL_B_VAL = 32'h0000_0000
) (
  input  wire logic [hwr_pkg::SEL_W-1:0]     i_sel,
  input  wire logic [hwr_pkg::CPU_NUM_W-1:0] i_cpu,
  input  wire logic [hwr_pkg::DATA_W-1:0]    i_count,
  input  wire logic [hwr_pkg::DATA_W-1:0]    i_thread,
  output logic [hwr_pkg::DATA_W-1:0]         o_value
);
  import hwr_pkg::*;

  always_comb begin
    case (i_sel)
      SEL_CPU_NUM:   o_value = {22'h000000, i_cpu};
      SEL_SYNC_STEP: o_value = SYNC_STEP;
      SEL_COUNT:     o_value = i_count;
      SEL_COUNT_RES: o_value = {16'h0000, CC_RES};
      SEL_THREAD:    o_value = i_thread;
      SEL_IMPL_A:    o_value = IMPL_A_VAL;
      SEL_IMPL_B:    o_value = IMPL_B_VAL;
      default:       o_value = 32'h0000_0000;
    endcase
  end
endmodule // hw_sel_mux

// >>> hw_register_read_unit_tb.sv
// self-checking bench for the hardware-register read unit
`timescale 1ns/100ps
module hw_register_read_unit_tb;
  import hwr_pkg::*;
  logic        i_clk;
  logic        i_rst;
  logic        i_valid;
  logic        i_cp0_enabled;
  logic        i_mask_we;
  logic        i_count_we;
  logic [4:0]  i_sel;
  logic [4:0]  i_dest_field;
  logic [9:0]  i_exception_base_cpu;
  logic [31:0] i_thread_local_word;
  logic [31:0] i_mask_wdata;
  logic [31:0] i_count_wdata;
  logic        o_wr_en;
  logic        o_ri_exc;
  logic        o_done;
  logic        r1_wr;
  logic        r1_exc;
  logic [4:0]  o_wr_addr;
  logic [31:0] o_wr_data;
  logic [31:0] o_hw_read_enable_mask;
  logic [31:0] o_count;
  logic [31:0] r1_cnt;
  int          bad_count = 0;
  int          tests_run = 0;

  hw_register_read_unit dut (
    .i_clk, .i_rst, .i_valid, .i_sel, .i_dest_field, .i_cp0_enabled, .i_exception_base_cpu,
    .i_thread_local_word, .i_mask_we, .i_mask_wdata, .i_count_we, .i_count_wdata,
    .o_wr_en, .o_wr_addr, .o_wr_data, .o_ri_exc, .o_done, .o_hw_read_enable_mask, .o_count
  );

  // first-release build with a half-rate counter shares every input
  hw_register_read_unit #(.ARCH_RELEASE(1), .CC_RES(16'h0002)) dut_r1 (
    .i_clk, .i_rst, .i_valid, .i_sel, .i_dest_field, .i_cp0_enabled, .i_exception_base_cpu,
    .i_thread_local_word, .i_mask_we, .i_mask_wdata, .i_count_we, .i_count_wdata,
    .o_wr_en(r1_wr), .o_wr_addr(), .o_wr_data(), .o_ri_exc(r1_exc), .o_done(),
    .o_hw_read_enable_mask(), .o_count(r1_cnt)
  );

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  // inputs always move 2 ns after the edge so sampling never races
  task automatic tick;
    @(posedge i_clk);
    #2;
  endtask

  // valid is left high so consecutive calls issue back to back
  task automatic rd(input logic [4:0] sel, input logic [4:0] dest, input logic cp0,
                    input logic ok, input logic [31:0] dat, input logic [4:0] adr);
    i_valid       = 1'b1;
    i_sel         = sel;
    i_dest_field  = dest;
    i_cp0_enabled = cp0;
    tick();
    chk1(o_done, 1'b1);
    chk1(o_wr_en, ok);
    chk1(o_ri_exc, !ok);
    chk32(o_wr_data, dat);
    chk32({27'h0, o_wr_addr}, {27'h0, adr});
  endtask

  task automatic t_reset;
    chk1(o_done, 1'b0);
    chk1(o_wr_en, 1'b0);
    chk32(o_hw_read_enable_mask, 32'h0000_0000);
    chk32(o_wr_data, 32'h0000_0000);
    chk1(o_ri_exc, 1'b0);
    chk32({27'h0, o_wr_addr}, 32'h0000_0000);
    chk32(o_count, 32'h0000_0000);
  endtask

  task automatic t_values;
    rd(SEL_CPU_NUM, 5'h03, 1'b1, 1'b1, 32'h0000_02A5, 5'h03);
    chk1(r1_exc, 1'b1);
    chk1(r1_wr, 1'b0);
    rd(SEL_SYNC_STEP, 5'h04, 1'b1, 1'b1, 32'h0000_0000, 5'h04);
    rd(SEL_COUNT_RES, 5'h05, 1'b1, 1'b1, 32'h0000_0001, 5'h05);
    rd(SEL_THREAD, 5'h06, 1'b1, 1'b1, 32'hCAFE_F00D, 5'h06);
    i_valid = 1'b0;
  endtask

  task automatic t_count;
    i_count_we    = 1'b1;
    i_count_wdata = 32'h0000_1000;
    tick();
    i_count_we = 1'b0;
    rd(SEL_COUNT, 5'h07, 1'b1, 1'b1, 32'h0000_1000, 5'h07);
    i_valid = 1'b0;
    chk32(o_count, 32'h0000_1000);
    tick();
    chk32(o_count, 32'h0000_1001);
    tick();
    chk32(r1_cnt, 32'h0000_1001);
    tick();
    tick();
    chk32(r1_cnt, 32'h0000_1002);
  endtask

  // every reserved and unbacked selector, back to back, destination kept
  task automatic t_reserved;
    for (int s = 4; s <= 28; s++) begin
      rd(5'(s), 5'h09, 1'b1, 1'b0, 32'h0000_1000, 5'h07);
    end
    rd(SEL_IMPL_A, 5'h09, 1'b1, 1'b0, 32'h0000_1000, 5'h07);
    rd(SEL_IMPL_B, 5'h09, 1'b1, 1'b0, 32'h0000_1000, 5'h07);
  endtask

  task automatic mask_wr(input logic [31:0] m);
    i_mask_we    = 1'b1;
    i_mask_wdata = m;
    tick();
    i_mask_we = 1'b0;
    chk32(o_hw_read_enable_mask, m);
  endtask

  task automatic t_mask;
    rd(SEL_COUNT, 5'h08, 1'b0, 1'b0, 32'h0000_1000, 5'h07);
    i_valid = 1'b0;
    mask_wr(32'h0000_0009);
    rd(SEL_CPU_NUM, 5'h0A, 1'b0, 1'b1, 32'h0000_02A5, 5'h0A);
    rd(SEL_SYNC_STEP, 5'h0B, 1'b0, 1'b0, 32'h0000_02A5, 5'h0A);
    rd(SEL_COUNT_RES, 5'h0C, 1'b0, 1'b1, 32'h0000_0001, 5'h0C);
    i_valid = 1'b0;
    mask_wr(32'hFFFF_FFFF);
    rd(SEL_RSVD_LO, 5'h0D, 1'b0, 1'b0, 32'h0000_0001, 5'h0C);
    rd(SEL_THREAD, 5'h0E, 1'b0, 1'b1, 32'hCAFE_F00D, 5'h0E);
    i_valid = 1'b0;
  endtask

  // reset in mid-run clears outputs, mask and counters; a read is taken at once
  task automatic t_midreset;
    i_rst = 1'b1;
    tick();
    i_rst = 1'b0;
    t_reset();
    chk32(r1_cnt, 32'h0000_0000);
    rd(SEL_COUNT_RES, 5'h01, 1'b1, 1'b1, 32'h0000_0001, 5'h01);
    i_valid = 1'b0;
  endtask

  initial begin
    repeat (4000) @(posedge i_clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    i_rst                = 1'b1;
    i_valid              = 1'b0;
    i_sel                = 5'h00;
    i_dest_field         = 5'h00;
    i_cp0_enabled        = 1'b0;
    i_exception_base_cpu = 10'h2A5;
    i_thread_local_word  = 32'hCAFE_F00D;
    i_mask_we            = 1'b0;
    i_mask_wdata         = 32'h0000_0000;
    i_count_we           = 1'b0;
    i_count_wdata        = 32'h0000_0000;
    repeat (3) tick();
    i_rst = 1'b0;
    t_reset();
    t_values();
    t_count();
    t_reserved();
    t_mask();
    t_midreset();
    tick();
    end_of_test();
  end
endmodule // hw_register_read_unit_tb
